/* File: twwp_params.svh */
// Constants shared by both ends of the wide transmit write port
`ifndef TWWP_PARAMS_SVH
`define TWWP_PARAMS_SVH
`define TWWP_WORD_W 64
`define TWWP_LINE_W 128
`define TWWP_MASK_W 8
`define TWWP_TAG_W 8
`define TWWP_SEL_W 3
`define TWWP_PARTS 8
`define TWWP_DEPTH 4
`define TWWP_MASK_ALL 8'hFF
`define TWWP_MASK_NONE 8'h00
`define TWWP_HALF_FIRST 1'h0
`define TWWP_HALF_SECOND 1'h1
`endif

/* File: twwp_pkg.sv */
// Types shared by both ends of the wide transmit write port
`default_nettype none
`include "twwp_params.svh"
package twwp_pkg;
  typedef logic [`TWWP_WORD_W-1:0] twwp_word_t;
  typedef logic [`TWWP_MASK_W-1:0] twwp_mask_t;
  typedef logic [`TWWP_TAG_W-1:0] twwp_tag_t;
  typedef logic [`TWWP_SEL_W-1:0] twwp_sel_t;
  typedef enum logic [1:0] {
    TWWP_ST_RUN = 2'b00,
    TWWP_ST_CLOSE = 2'b01
  } twwp_state_t;

  // Forces a mask to a run of set bits from the top lane down
  function automatic twwp_mask_t twwp_top_run(input twwp_mask_t m);
    twwp_mask_t r;
    r = `TWWP_MASK_NONE;
    for (int i = `TWWP_MASK_W - 1; i >= 0; i--) begin
      r[i] = m[i] && (i == `TWWP_MASK_W - 1 || r[(i + 1) % `TWWP_MASK_W]);
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* File: twwp_if.sv */
// Push interface between application writer and transmit buffer core
`timescale 1ns/100ps
`default_nettype none
interface twwp_if;
  import twwp_pkg::*;
  twwp_word_t push_word;
  twwp_mask_t byte_valid_mask;
  logic packet_first_flag;
  logic packet_last_flag;
  logic packet_abort_flag;
  logic word_write_strobe;
  twwp_tag_t channel_tag;
  logic line_close_strobe;
  logic buffer_poll_disable;
  twwp_sel_t partition_select;
  logic partition_full_flag;
  modport app (
    output push_word, byte_valid_mask, packet_first_flag, packet_last_flag,
    output packet_abort_flag, word_write_strobe, channel_tag, line_close_strobe,
    output buffer_poll_disable, partition_select,
    input partition_full_flag
  );
  modport core (
    input push_word, byte_valid_mask, packet_first_flag, packet_last_flag,
    input packet_abort_flag, word_write_strobe, channel_tag, line_close_strobe,
    input buffer_poll_disable, partition_select,
    output partition_full_flag
  );
endinterface
`default_nettype wire

/* File: twwp_core.sv */
// Transmit buffer core: partitioned line store, write pointers, drain
`timescale 1ns/100ps
`default_nettype none
`include "twwp_params.svh"
module twwp_core
  import twwp_pkg::*;
#(
  parameter int DEPTH = `TWWP_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Push side from the application
  twwp_if.core APP,
  // Fill level for the full flag
  input wire logic [AW:0] FILL_LEVEL,
  // Drained lines toward the link
  output logic [`TWWP_LINE_W-1:0] LINE_DATA,
  output logic [2*`TWWP_MASK_W-1:0] LINE_MASK,
  output logic [`TWWP_TAG_W-1:0] LINE_TAG,
  output logic [`TWWP_SEL_W-1:0] LINE_PART,
  output logic LINE_FIRST,
  output logic LINE_LAST,
  output logic LINE_ABORT,
  output logic LINE_VALID,
  output logic LINE_IDLE
);
  localparam int P = `TWWP_PARTS;
  localparam int W = `TWWP_WORD_W;
  localparam int M = `TWWP_MASK_W;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  // Line store and per-partition pointers
  logic [`TWWP_LINE_W-1:0] data_r [P][DEPTH];
  logic [`TWWP_LINE_W-1:0] data_nxt [P][DEPTH];
  logic [2*M-1:0] mask_r [P][DEPTH];
  logic [2*M-1:0] mask_nxt [P][DEPTH];
  twwp_tag_t tag_r [P][DEPTH];
  twwp_tag_t tag_nxt [P][DEPTH];
  logic [2:0] flg_r [P][DEPTH];
  logic [2:0] flg_nxt [P][DEPTH];
  logic [AW-1:0] wp_r [P];
  logic [AW-1:0] wp_nxt [P];
  logic [AW-1:0] rp_r [P];
  logic [AW-1:0] rp_nxt [P];
  logic [AW:0] occ_r [P];
  logic [AW:0] occ_nxt [P];
  logic half_r [P];
  logic half_nxt [P];
  twwp_sel_t rr_r, rr_nxt;
  logic full_r, full_nxt;
  logic [`TWWP_LINE_W-1:0] ld_nxt;
  logic [2*M-1:0] lm_nxt;
  twwp_tag_t lt_nxt;
  twwp_sel_t lp_nxt;
  logic [2:0] lf_nxt;
  logic lv_nxt, li_nxt;
  logic [`TWWP_LINE_W-1:0] ld_r;
  logic [2*M-1:0] lm_r;
  twwp_tag_t lt_r;
  twwp_sel_t lp_r;
  logic [2:0] lf_r;
  logic lv_r, li_r;

  twwp_sel_t sel, pk;
  logic [AW-1:0] w;
  logic room, take, adv, found;
  logic inc [P];
  logic dec [P];

  // Write, line advance, drain and occupancy next values
  always_comb begin
    data_nxt = data_r;
    mask_nxt = mask_r;
    tag_nxt = tag_r;
    flg_nxt = flg_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    half_nxt = half_r;
    occ_nxt = occ_r;
    rr_nxt = rr_r;
    ld_nxt = ld_r;
    lm_nxt = lm_r;
    lt_nxt = lt_r;
    lp_nxt = lp_r;
    lf_nxt = lf_r;
    lv_nxt = 1'b0;
    li_nxt = 1'b1;
    pk = rr_r;
    found = 1'b0;
    for (int i = 0; i < P; i++) begin
      inc[i] = 1'b0;
      dec[i] = 1'b0;
    end
    sel = APP.partition_select;
    w = wp_r[sel];
    room = occ_r[sel] != FULL_CNT;
    take = APP.word_write_strobe && (APP.byte_valid_mask != `TWWP_MASK_NONE)
      && room;
    adv = 1'b0;
    if (take) begin
      if (half_r[sel] == `TWWP_HALF_FIRST) begin
        // First push fills the upper half, lane n by mask bit n
        data_nxt[sel][w][2*W-1:W] = APP.push_word;
        mask_nxt[sel][w] = {APP.byte_valid_mask, `TWWP_MASK_NONE};
        tag_nxt[sel][w] = APP.channel_tag;
        flg_nxt[sel][w] = {APP.packet_first_flag, APP.packet_last_flag,
          APP.packet_abort_flag};
        adv = APP.packet_last_flag;
      end else begin
        data_nxt[sel][w][W-1:0] = APP.push_word;
        mask_nxt[sel][w][M-1:0] = APP.byte_valid_mask;
        flg_nxt[sel][w][1:0] = {APP.packet_last_flag, APP.packet_abort_flag};
        adv = 1'b1;
      end
      half_nxt[sel] = ~half_r[sel];
    end
    // Close commits the current line, empty halves masked off
    if (APP.line_close_strobe && room) begin
      if (half_r[sel] == `TWWP_HALF_FIRST && !take) begin
        mask_nxt[sel][w] = {2 * M{1'b0}};
        flg_nxt[sel][w] = 3'h0;
      end
      adv = 1'b1;
    end
    if (adv) begin
      wp_nxt[sel] = w + 1'b1;
      half_nxt[sel] = `TWWP_HALF_FIRST;
      inc[sel] = 1'b1;
    end
    // Round-robin drain of one line a cycle unless disabled
    if (!APP.buffer_poll_disable) begin
      for (int k = 0; k < P; k++) begin
        if (!found && occ_r[rr_r + k[2:0]] != '0) begin
          found = 1'b1;
          pk = rr_r + k[2:0];
        end
      end
    end
    if (found) begin
      ld_nxt = data_r[pk][rp_r[pk]];
      lm_nxt = mask_r[pk][rp_r[pk]];
      lt_nxt = tag_r[pk][rp_r[pk]];
      lf_nxt = flg_r[pk][rp_r[pk]];
      lp_nxt = pk;
      lv_nxt = 1'b1;
      li_nxt = 1'b0;
      rp_nxt[pk] = rp_r[pk] + 1'b1;
      rr_nxt = pk + 1'b1;
      dec[pk] = 1'b1;
    end
    li_nxt = !found;
    for (int i = 0; i < P; i++) begin
      occ_nxt[i] = occ_r[i] + {{AW{1'b0}}, inc[i]} - {{AW{1'b0}}, dec[i]};
    end
    full_nxt = occ_nxt[APP.partition_select] >= FILL_LEVEL;
  end

  // Register stage, all state on the rising clock edge
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < P; i++) begin
        for (int j = 0; j < DEPTH; j++) begin
          data_r[i][j] <= '0;
          mask_r[i][j] <= '0;
          tag_r[i][j] <= '0;
          flg_r[i][j] <= 3'h0;
        end
        wp_r[i] <= '0;
        rp_r[i] <= '0;
        occ_r[i] <= '0;
        half_r[i] <= `TWWP_HALF_FIRST;
      end
      rr_r <= '0;
      full_r <= 1'b0;
      ld_r <= '0;
      lm_r <= '0;
      lt_r <= '0;
      lp_r <= '0;
      lf_r <= 3'h0;
      lv_r <= 1'b0;
      li_r <= 1'b1;
    end else begin
      data_r <= data_nxt;
      mask_r <= mask_nxt;
      tag_r <= tag_nxt;
      flg_r <= flg_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      occ_r <= occ_nxt;
      half_r <= half_nxt;
      rr_r <= rr_nxt;
      full_r <= full_nxt;
      ld_r <= ld_nxt;
      lm_r <= lm_nxt;
      lt_r <= lt_nxt;
      lp_r <= lp_nxt;
      lf_r <= lf_nxt;
      lv_r <= lv_nxt;
      li_r <= li_nxt;
    end
  end

  // Outputs straight from registers
  assign APP.partition_full_flag = full_r;
  assign LINE_DATA = ld_r;
  assign LINE_MASK = lm_r;
  assign LINE_TAG = lt_r;
  assign LINE_PART = lp_r;
  assign LINE_FIRST = lf_r[2];
  assign LINE_LAST = lf_r[1];
  assign LINE_ABORT = lf_r[0];
  assign LINE_VALID = lv_r;
  assign LINE_IDLE = li_r;
endmodule
`default_nettype wire

/* File: twwp_writer.sv */
// Application writer: turns user packet words into paired pushes
`timescale 1ns/100ps
`default_nettype none
`include "twwp_params.svh"
module twwp_writer
  import twwp_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Push side toward the core
  twwp_if.app APP,
  // User word stream
  input wire logic [`TWWP_WORD_W-1:0] USER_WORD,
  input wire logic [`TWWP_MASK_W-1:0] USER_MASK,
  input wire logic [`TWWP_TAG_W-1:0] USER_TAG,
  input wire logic [`TWWP_SEL_W-1:0] USER_PART,
  input wire logic USER_FIRST,
  input wire logic USER_LAST,
  input wire logic USER_ABORT,
  input wire logic USER_VALID,
  output logic USER_READY,
  // Buffer control
  input wire logic USER_HOLD
);
  localparam int P = `TWWP_PARTS;

  twwp_state_t st_r, st_nxt;
  logic half_r [P];
  logic half_nxt [P];
  twwp_word_t word_r, word_nxt;
  twwp_mask_t mask_r, mask_nxt;
  twwp_tag_t tag_r, tag_nxt;
  twwp_sel_t sel_r, sel_nxt;
  logic first_r, first_nxt, last_r, last_nxt, abort_r, abort_nxt;
  logic we_r, we_nxt, close_r, close_nxt, hold_r;
  logic go;

  // Ready while selected partition is below the fill level and no close pending
  assign USER_READY = !APP.partition_full_flag && st_r == TWWP_ST_RUN;
  assign go = USER_VALID && USER_READY;

  // Next push; a first word on a half-filled line closes it first
  always_comb begin
    st_nxt = st_r;
    half_nxt = half_r;
    word_nxt = word_r;
    mask_nxt = mask_r;
    tag_nxt = tag_r;
    sel_nxt = sel_r;
    first_nxt = first_r;
    last_nxt = last_r;
    abort_nxt = abort_r;
    we_nxt = 1'b0;
    close_nxt = 1'b0;
    case (st_r)
      TWWP_ST_RUN: begin
        if (go && USER_FIRST && half_r[USER_PART] == `TWWP_HALF_SECOND) begin
          close_nxt = 1'b1;
          sel_nxt = USER_PART;
          half_nxt[USER_PART] = `TWWP_HALF_FIRST;
          st_nxt = TWWP_ST_CLOSE;
        end else if (go) begin
          word_nxt = USER_WORD;
          mask_nxt = USER_LAST ? twwp_top_run(USER_MASK) : `TWWP_MASK_ALL;
          tag_nxt = USER_TAG;
          sel_nxt = USER_PART;
          first_nxt = USER_FIRST;
          last_nxt = USER_LAST;
          abort_nxt = USER_ABORT && USER_LAST;
          we_nxt = 1'b1;
          half_nxt[USER_PART] = USER_LAST ? `TWWP_HALF_FIRST
            : ~half_r[USER_PART];
        end
      end
      TWWP_ST_CLOSE: begin
        st_nxt = TWWP_ST_RUN;
      end
      default: begin
        st_nxt = TWWP_ST_RUN;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r <= TWWP_ST_RUN;
      for (int i = 0; i < P; i++) begin
        half_r[i] <= `TWWP_HALF_FIRST;
      end
      word_r <= '0;
      mask_r <= `TWWP_MASK_NONE;
      tag_r <= '0;
      sel_r <= '0;
      first_r <= 1'b0;
      last_r <= 1'b0;
      abort_r <= 1'b0;
      we_r <= 1'b0;
      close_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      half_r <= half_nxt;
      word_r <= word_nxt;
      mask_r <= mask_nxt;
      tag_r <= tag_nxt;
      sel_r <= sel_nxt;
      first_r <= first_nxt;
      last_r <= last_nxt;
      abort_r <= abort_nxt;
      we_r <= we_nxt;
      close_r <= close_nxt;
      hold_r <= USER_HOLD;
    end
  end

  // Pin drive from registers
  assign APP.push_word = word_r;
  assign APP.byte_valid_mask = mask_r;
  assign APP.channel_tag = tag_r;
  assign APP.partition_select = sel_r;
  assign APP.packet_first_flag = first_r && we_r;
  assign APP.packet_last_flag = last_r && we_r;
  assign APP.packet_abort_flag = abort_r && we_r;
  assign APP.word_write_strobe = we_r;
  assign APP.line_close_strobe = close_r;
  assign APP.buffer_poll_disable = hold_r;
endmodule
`default_nettype wire

/* File: twwp_monitor.sv */
// Checker of the push interface between writer and core
`timescale 1ns/100ps
`default_nettype none
module twwp_monitor
  import twwp_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Push interface
  input wire twwp_mask_t byte_valid_mask,
  input wire logic packet_first_flag,
  input wire logic packet_last_flag,
  input wire logic packet_abort_flag,
  input wire logic word_write_strobe,
  input wire logic line_close_strobe,
  input wire logic partition_full_flag
);
  logic half_r;
  logic half_nxt;
  twwp_mask_t gap;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Lanes left unqualified by the mask
  assign gap = ~byte_valid_mask;
  // Tracks a line holding one push
  always_comb begin
    half_nxt = half_r;
    if (line_close_strobe) begin
      half_nxt = 1'b0;
    end else if (word_write_strobe && byte_valid_mask != 8'h00) begin
      half_nxt = !half_r && !packet_last_flag;
    end
  end
  // Half position register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      half_r <= 1'b0;
    end else begin
      half_r <= half_nxt;
    end
  end
  // Close pulse, then a quiet cycle
  sequence close_gap_s;
    ##1 !word_write_strobe && !line_close_strobe;
  endsequence
  abort_with_last_a: assert property (
    word_write_strobe && packet_abort_flag |-> packet_last_flag)
    else $error("abort push without packet end");
  full_mask_a: assert property (
    word_write_strobe && !packet_last_flag |-> byte_valid_mask == 8'hFF)
    else $error("partial mask before packet end");
  top_run_a: assert property (
    word_write_strobe |-> (gap & (gap + 8'h01)) == 8'h00)
    else $error("mask not a run from the top lane");
  first_position_a: assert property (
    word_write_strobe && packet_first_flag |-> !half_r)
    else $error("packet start on second push");
  close_pending_a: assert property (
    line_close_strobe |-> half_r && !word_write_strobe)
    else $error("close without a half line");
  close_gap_a: assert property (line_close_strobe |-> close_gap_s)
    else $error("push right after close");
  full_stop_a: assert property (partition_full_flag |=> !word_write_strobe)
    else $error("push while partition full");
  reset_full_a: assert property ($fell(RST) |-> !partition_full_flag)
    else $error("full flag after reset");
endmodule
`default_nettype wire

/* File: test_tx_wide_write_port.sv */
// Bench joining writer and core through the push interface
`timescale 1ns/100ps
`default_nettype none
module test_tx_wide_write_port
  import twwp_pkg::*;
;
  typedef struct {
    logic [127:0] d;
    logic [15:0] m;
    twwp_tag_t t;
    twwp_sel_t p;
    logic [2:0] f;
  } twwp_exp_t;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  twwp_word_t u_word = '0;
  twwp_mask_t u_mask = '0;
  twwp_tag_t u_tag = '0;
  twwp_sel_t u_part = '0;
  logic u_first = 1'b0;
  logic u_last = 1'b0;
  logic u_abort = 1'b0;
  logic u_valid = 1'b0;
  logic u_hold = 1'b0;
  logic [2:0] fill = 3'h4;
  logic ready;
  logic [127:0] l_data;
  logic [15:0] l_mask;
  twwp_tag_t l_tag;
  twwp_sel_t l_part;
  logic l_first, l_last, l_abort, l_valid, l_idle;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  twwp_exp_t exp_q[$];
  twwp_exp_t e;
  twwp_if bus();
  twwp_writer twwp_writer_i(.CLOCK(CLOCK), .RST(RST), .APP(bus), .USER_WORD(u_word),
    .USER_MASK(u_mask), .USER_TAG(u_tag), .USER_PART(u_part), .USER_FIRST(u_first),
    .USER_LAST(u_last), .USER_ABORT(u_abort), .USER_VALID(u_valid), .USER_READY(ready),
    .USER_HOLD(u_hold));
  twwp_core twwp_core_i(.CLOCK(CLOCK), .RST(RST), .APP(bus), .FILL_LEVEL(fill),
    .LINE_DATA(l_data), .LINE_MASK(l_mask), .LINE_TAG(l_tag), .LINE_PART(l_part),
    .LINE_FIRST(l_first), .LINE_LAST(l_last), .LINE_ABORT(l_abort), .LINE_VALID(l_valid),
    .LINE_IDLE(l_idle));
  twwp_monitor twwp_monitor_i(.CLOCK(CLOCK), .RST(RST),
    .byte_valid_mask(bus.byte_valid_mask), .packet_first_flag(bus.packet_first_flag),
    .packet_last_flag(bus.packet_last_flag), .packet_abort_flag(bus.packet_abort_flag),
    .word_write_strobe(bus.word_write_strobe), .line_close_strobe(bus.line_close_strobe),
    .partition_full_flag(bus.partition_full_flag));
  // Clock generator
  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  function automatic logic [127:0] lanes(input logic [15:0] m);
    for (int i = 0; i < 16; i++) lanes[i*8 +: 8] = {8{m[i]}};
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t got %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Offers one word, again if the writer closed a line instead
  task automatic push(input twwp_word_t w, input twwp_mask_t m, input twwp_tag_t t,
      input twwp_sel_t p, input logic [2:0] f);
    int n;
    n = 0;
    u_word = w;
    u_mask = m;
    u_tag = t;
    u_part = p;
    {u_first, u_last, u_abort} = f;
    u_valid = 1'b1;
    #1;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge CLOCK);
      #1;
      n++;
    end
    @(negedge CLOCK);
    if (bus.line_close_strobe === 1'b1) push(w, m, t, p, f);
  endtask
  task automatic drain();
    repeat (20) @(negedge CLOCK);
    check(128'(exp_q.size()), 128'h0);
  endtask
  // Compares each drained line with the oldest expected one
  always @(negedge CLOCK) begin
    if (l_valid === 1'b1) begin
      check(128'(exp_q.size() > 0), 128'h1);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check(l_data & lanes(e.m), e.d & lanes(e.m));
        check(128'(l_mask), 128'(e.m));
        check(128'(l_tag), 128'(e.t));
        check(128'(l_part), 128'(e.p));
        check(128'({l_first, l_last, l_abort}), 128'(e.f));
      end
    end
  end
  // Cuts a hang short
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge CLOCK);
    RST = 1'b0;
    @(negedge CLOCK);
    check(128'(l_idle), 128'h1);
    exp_q.push_back('{{64'h0102030405060708, 64'h1112131415161718}, 16'hFF80, 8'h11,
      3'h1, 3'b110});
    push(64'h0102030405060708, 8'h0F, 8'h11, 3'h1, 3'b100);
    push(64'h1112131415161718, 8'hB0, 8'h11, 3'h1, 3'b010);
    // Last word whose mask has no top lane reaches the core all-zero
    push(64'hDEAD, 8'h7F, 8'h22, 3'h2, 3'b010);
    u_valid = 1'b0;
    drain();
    $display("test pair done");
    for (int p = 0; p < 8; p++) begin
      exp_q.push_back('{{64'(p) * 64'h0101, 64'h0}, {8'hFF << p, 8'h00}, 8'hA0 + 8'(p),
        3'(p), {2'b11, p[0]}});
      push(64'(p) * 64'h0101, 8'hFF << p, 8'hA0 + 8'(p), 3'(p), {2'b11, p[0]});
      u_valid = 1'b0;
      drain();
    end
    $display("test partitions done");
    exp_q.push_back('{{64'hAA, 64'h0}, 16'hFF00, 8'h55, 3'h5, 3'b100});
    exp_q.push_back('{{64'hBB, 64'h0}, 16'hFF00, 8'h55, 3'h5, 3'b110});
    push(64'hAA, 8'hFF, 8'h55, 3'h5, 3'b100);
    push(64'hBB, 8'hFF, 8'h55, 3'h5, 3'b110);
    u_valid = 1'b0;
    drain();
    $display("test close done");
    u_hold = 1'b1;
    for (int i = 0; i < 8; i++) begin
      push(64'(i) + 64'hC0, 8'hFF, 8'h33, 3'h3, {i == 0, 2'b00});
    end
    u_valid = 1'b0;
    repeat (4) begin
      @(negedge CLOCK);
      check(128'(l_idle), 128'h1);
    end
    check(128'(ready), 128'h0);
    // Raising the fill level above occupancy releases the full flag
    fill = 3'h5;
    @(negedge CLOCK);
    check(128'(ready), 128'h1);
    for (int i = 0; i < 8; i += 2) begin
      exp_q.push_back('{{64'(i) + 64'hC0, 64'(i) + 64'hC1}, 16'hFFFF, 8'h33, 3'h3,
        {i == 0, 2'b00}});
    end
    u_hold = 1'b0;
    drain();
    $display("test hold done");
    stop_test();
  end
endmodule
`default_nettype wire
